// File: core/dwt_pkg.sv
// Package: register map, field layout and types of the dual-width timer
package dwt_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_CONTROL_A  = 8'h08;
  localparam logic [7:0] OFS_CONTROL_B  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_FLAG   = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_POWER      = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CA_ON_BIT    = 7;
  localparam int CA_OUT_BIT   = 5;
  localparam int CA_WIDE_BIT  = 4;
  localparam int CB_ASYNC_BIT = 4;
  localparam int CB_CS_LSB    = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_COUNT_LOW  = 8'h00;
  localparam logic [7:0] RST_COUNT_HIGH = 8'hFF;
  localparam logic [7:0] RST_CONTROL    = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       on;
    logic       wide;
    logic [3:0] post;
  } dwt_ctrl_a_t;

  typedef struct packed {
    logic [2:0] src;
    logic       unsync;
    logic [3:0] pre;
  } dwt_ctrl_b_t;

  typedef struct packed {
    logic match_pulse;
    logic timer_out;
    logic irq;
    logic wake;
  } dwt_out_t;

endpackage

// File: core/dwt_timer.sv
// Module: dual-width timer/counter with AXI4-Lite register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module dwt_timer (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic [7:0]    clk_src_in,
  input  wire logic          sleep_in,
  output dwt_pkg::dwt_out_t  tmr_out
);
  import dwt_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dwt_ctrl_a_t ca_q, ca_d;
  dwt_ctrl_b_t cb_q, cb_d;
  logic [7:0]  low_q, low_d, high_q, high_d, hbuf_q, hbuf_d, per_q, per_d;
  logic [14:0] pre_q, pre_d;
  logic [3:0]  post_q, post_d;
  logic        flag_q, flag_d, ie_q, ie_d;
  logic        tout_q, tout_d, pulse_q, pulse_d;
  logic [7:0]  s1_q, s2_q, s3_q;
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;

  // ---------------------------------------------------------------
  // Source select and edge detection
  // ---------------------------------------------------------------
  // Async mode here still samples: one clock domain only; the raw
  // rate limit is therefore the same as synced mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end else begin
      s1_q <= clk_src_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic src_lvl, src_prev, src_rise, tick_src, pre_tick, evt, run;
  assign src_lvl  = s2_q[cb_q.src];
  assign src_prev = s3_q[cb_q.src];
  // Source 2 is the instruction clock: every aclk is one cycle
  assign tick_src = (cb_q.src == 3'd2) ? 1'b1 : (src_lvl & ~src_prev);
  assign src_rise = tick_src;
  // Synced timer halts in sleep; unsynced keeps counting
  assign run = ca_q.on & (~sleep_in | cb_q.unsync);
  // Prescaler output: all selected low bits wrap together
  // Code 15 shifts the one out, so the mask is all ones: 1:32768
  always_comb begin
    pre_tick = 1'b0;
    if (cb_q.pre == 4'h0) begin
      pre_tick = src_rise;
    end else begin
      pre_tick = src_rise &
        (&(pre_q | ~((15'h0001 << cb_q.pre) - 15'h0001)));
    end
  end

  logic rd_low, wr_fire;
  logic [7:0] wa;
  assign wa = awa_q;
  assign wr_fire = aw_q & w_q & ~b_q;
  assign rd_low  = s_axi_arvalid & s_axi_arready &
                   (s_axi_araddr == OFS_COUNT_LOW);

  // ---------------------------------------------------------------
  // Timer core
  // ---------------------------------------------------------------
  always_comb begin
    ca_d = ca_q; cb_d = cb_q; low_d = low_q; high_d = high_q;
    hbuf_d = hbuf_q; per_d = per_q; pre_d = pre_q; post_d = post_q;
    flag_d = flag_q; ie_d = ie_q; tout_d = tout_q; pulse_d = pulse_q;
    evt = 1'b0;
    if (run && src_rise) begin
      pre_d = pre_q + 15'h0001;
    end
    if (run && pre_tick) begin
      pulse_d = 1'b0;
      if (ca_q.wide) begin
        {high_d, low_d} = {high_q, low_q} + 16'h0001;
        evt = ({high_q, low_q} == 16'hFFFF);
      end else if (low_q == per_q) begin
        low_d = 8'h00;
        per_d = high_q;
        evt   = 1'b1;
      end else begin
        low_d = low_q + 8'h01;
      end
      if (evt) begin
        if (post_q == ca_q.post) begin
          post_d  = 4'h0;
          pulse_d = 1'b1;
        end else begin
          post_d = post_q + 4'h1;
        end
      end
    end
    if (pulse_d && !pulse_q) begin
      tout_d = ~tout_q;
    end
    if (rd_low && ca_q.wide) begin
      hbuf_d = high_q;
    end
    if (wr_fire) begin
      if (wa == OFS_COUNT_LOW) begin
        low_d = wd_q[7:0];
        if (ca_q.wide) high_d = hbuf_q;
        pre_d = 15'h0000;
        post_d = 4'h0;
      end
      if (wa == OFS_COUNT_HIGH) begin
        if (ca_q.wide) hbuf_d = wd_q[7:0];
        else high_d = wd_q[7:0];
      end
      if (wa == OFS_CONTROL_A) begin
        ca_d = '{wd_q[CA_ON_BIT], wd_q[CA_WIDE_BIT], wd_q[3:0]};
        pre_d = 15'h0000;
        post_d = 4'h0;
      end
      if (wa == OFS_CONTROL_B) begin
        cb_d = '{wd_q[CB_CS_LSB+2:CB_CS_LSB], wd_q[CB_ASYNC_BIT], wd_q[3:0]};
        pre_d = 15'h0000;
        post_d = 4'h0;
      end
      if (wa == OFS_IRQ_FLAG && !wd_q[0]) begin
        flag_d = 1'b0;
      end
      if (wa == OFS_IRQ_ENABLE) begin
        ie_d = wd_q[0];
      end
    end
    if (pulse_d && !pulse_q) begin
      flag_d = 1'b1; // set wins over clear
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ca_q   <= '0;
      cb_q   <= '0;
      low_q  <= RST_COUNT_LOW;
      high_q <= RST_COUNT_HIGH;
      hbuf_q <= RST_COUNT_HIGH;
      per_q  <= RST_COUNT_HIGH;
      pre_q  <= 15'h0000;
      post_q <= 4'h0;
      flag_q <= 1'b0;
      ie_q   <= 1'b0;
      tout_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      ca_q   <= ca_d;
      cb_q   <= cb_d;
      low_q  <= low_d;
      high_q <= high_d;
      hbuf_q <= hbuf_d;
      per_q  <= per_d;
      pre_q  <= pre_d;
      post_q <= post_d;
      flag_q <= flag_d;
      ie_q   <= ie_d;
      tout_q <= tout_d;
      pulse_q <= pulse_d;
    end
  end

  assign tmr_out.match_pulse = pulse_q;
  assign tmr_out.timer_out   = tout_q;
  assign tmr_out.irq         = flag_q & ie_q;
  assign tmr_out.wake        = flag_q & ie_q & cb_q.unsync;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic [7:0] hi_view;
  logic       map_ok;
  assign hi_view = ca_q.wide ? hbuf_q : high_q;

  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q; awa_d = awa_q;
    wd_d = wd_q; rd_d = rd_q; br_d = br_q; rr_d = rr_q;
    // Offset 18h holds no register: writes answer SLVERR like reads
    map_ok = (awa_q < OFS_POWER) && (awa_q[1:0] == 2'b00);
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
    end
    if (wr_fire) begin
      aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1;
      br_d = map_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_d = 1'b1;
      rr_d = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_COUNT_LOW:  rd_d = {24'h00_0000, low_q};
        OFS_COUNT_HIGH: rd_d = {24'h00_0000, hi_view};
        OFS_CONTROL_A:  rd_d = {24'h00_0000, ca_q.on, 1'b0, tout_q,
                                ca_q.wide, ca_q.post};
        OFS_CONTROL_B:  rd_d = {24'h00_0000, cb_q};
        OFS_IRQ_FLAG:   rd_d = {31'h0000_0000, flag_q};
        OFS_IRQ_ENABLE: rd_d = {31'h0000_0000, ie_q};
        default: begin
          rd_d = 32'h0000_0000;
          rr_d = RESP_SLVERR;
        end
      endcase
    end
    if (r_q && s_axi_rready) r_d = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awa_q <= 8'h00; wd_q <= 32'h0000_0000; rd_q <= 32'h0000_0000;
      br_q <= RESP_OKAY; rr_q <= RESP_OKAY;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awa_q <= awa_d; wd_q <= wd_d; rd_q <= rd_d;
      br_q <= br_d; rr_q <= rr_d;
    end
  end

  assign s_axi_awready = ~aw_q & ~b_q;
  assign s_axi_wready  = ~w_q & ~b_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = ~r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_reset_values: assert property (
    $rose(aresetn) |-> (low_q == 8'h00 && high_q == 8'hFF))
    else $error("Count reset values wrong");
  chk_match_clear: assert property (
    (run && pre_tick && !ca_q.wide && low_q == per_q && !wr_fire)
    |=> low_q == 8'h00)
    else $error("Match did not clear low count");
  chk_wide_inc: assert property (
    (run && pre_tick && ca_q.wide && !wr_fire)
    |=> {high_q, low_q} == $past({high_q, low_q}) + 16'h0001)
    else $error("Wide count did not advance");
  chk_read_latch: assert property (
    (rd_low && ca_q.wide && !wr_fire) |=> hbuf_q == $past(high_q))
    else $error("High buffer not latched");
  chk_scaler_clear: assert property (
    (wr_fire && (wa == OFS_CONTROL_A || wa == OFS_CONTROL_B))
    |=> (pre_q == 15'h0000 && post_q == 4'h0))
    else $error("Scalers not cleared");
  chk_toggle_out: assert property (
    $rose(pulse_q) |-> tout_q != $past(tout_q))
    else $error("Output did not toggle");
  chk_flag_sticky: assert property (
    (flag_q && !(wr_fire && wa == OFS_IRQ_FLAG)) |=> flag_q)
    else $error("Flag dropped by itself");
  chk_sleep_halt: assert property (
    (sleep_in && !cb_q.unsync && !wr_fire) |=> low_q == $past(low_q))
    else $error("Synced timer ran in sleep");
  chk_irq_gate: assert property (
    tmr_out.irq == (flag_q && ie_q))
    else $error("Interrupt gate wrong");
  chk_flag_set: assert property (
    $rose(pulse_q) |-> flag_q)
    else $error("Flag not set by pulse");
  chk_pulse_short: assert property (
    (run && pre_tick && !evt) |=> !pulse_q)
    else $error("Pulse outlived one period");
  chk_wide_event: assert property (
    (run && pre_tick && ca_q.wide && {high_q, low_q} == 16'hFFFF &&
     post_q == ca_q.post) |=> (pulse_q && flag_q))
    else $error("Rollover raised no event");
  chk_low_clear: assert property (
    (wr_fire && wa == OFS_COUNT_LOW)
    |=> (pre_q == 15'h0000 && post_q == 4'h0))
    else $error("Low write left scalers running");
  chk_async_sleep: assert property (
    (sleep_in && cb_q.unsync && run && src_rise && cb_q.pre == 4'h0 &&
     !ca_q.wide && low_q != per_q && !wr_fire)
    |=> low_q == $past(low_q) + 8'h01)
    else $error("Unsynced count stalled in sleep");
  chk_period_load: assert property (
    (run && pre_tick && !ca_q.wide && low_q == per_q)
    |=> per_q == $past(high_q))
    else $error("Period buffer not reloaded");
  chk_wide_write: assert property (
    (wr_fire && wa == OFS_COUNT_LOW && ca_q.wide)
    |=> high_q == $past(hbuf_q))
    else $error("Upper byte not loaded from buffer");

endmodule
`default_nettype wire

// File: verif/dwt_src_model.sv
// Model of the external count source feeding the timer's clock input
`timescale 1ns/1ps
`default_nettype none
module dwt_src_model (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] num,
  output var  logic       clk_out,
  output var  logic       busy
);
  // Eight aclk per edge keeps the source below a quarter of aclk
  initial begin
    clk_out = 1'b0;
    busy    = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        repeat (num) begin
          repeat (4) @(posedge aclk);
          clk_out <= 1'b1;
          repeat (4) @(posedge aclk);
          clk_out <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Register-level self-checking bench of the dual-width timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dwt_pkg::*;
  logic        aclk, aresetn, awv, wv, bready, arv, rready, sleep_in;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, go, busy, sclk;
  logic [7:0]  awaddr, araddr, num, rdv, mp_q, to_q;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, rsp;
  dwt_out_t    tmr_out;
  int          num_errors, cmp_count, n_rise, n_tog, r0, t0;

  dwt_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .clk_src_in({7'h00, sclk}),
    .sleep_in(sleep_in), .tmr_out(tmr_out));
  dwt_src_model src_u (.aclk(aclk), .go(go), .num(num), .clk_out(sclk),
    .busy(busy));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Pulse rises and output toggles, counted from reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      mp_q   <= 8'h00;
      to_q   <= 8'h00;
      n_rise <= 0;
      n_tog  <= 0;
    end else begin
      mp_q <= {7'h00, tmr_out.match_pulse};
      to_q <= {7'h00, tmr_out.timer_out};
      if (tmr_out.match_pulse && !mp_q[0]) n_rise <= n_rise + 1;
      if (tmr_out.timer_out !== to_q[0]) n_tog <= n_tog + 1;
    end
  end

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("BAD %0t no answer", $time);
    end_sim();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata  <= {24'h00_0000, d};
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      ha = awv && awrdy;
      hw = wv && wrdy;
      hb = bvalid;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge aclk);
      if (!arrdy && !rvalid) continue;
      @(posedge aclk);
      arv <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rdv = rdata[7:0];
        rsp = rresp;
        return;
      end
    end
    hang();
  endtask
  task automatic edges(input logic [7:0] k);
    @(posedge aclk);
    go  <= 1'b1;
    num <= k;
    @(posedge aclk);
    go <= 1'b0;
    for (int n = 0; n < 4000; n++) begin
      @(negedge aclk);
      if (!busy) begin
        repeat (4) @(posedge aclk);
        return;
      end
    end
    hang();
  endtask
  // Pulse and toggle counts over a window must both land in lo..hi
  task automatic span(input int lo, input int hi);
    r0 = n_rise;
    t0 = n_tog;
    repeat (40) @(posedge aclk);
    @(negedge aclk);
    chk({7'h00, n_rise - r0 >= lo && n_rise - r0 <= hi}, 8'h01);
    chk({7'h00, n_tog - t0 >= lo && n_tog - t0 <= hi}, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    {awv, wv, bready, arv, rready, sleep_in, go} = '0;
    {awaddr, araddr, num, wdata} = '0;
    {num_errors, cmp_count} = '0;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_COUNT_LOW); chk(rdv, RST_COUNT_LOW);
    rd(OFS_COUNT_HIGH); chk(rdv, RST_COUNT_HIGH);
    rd(OFS_POWER); chk({6'h00, rsp}, {6'h00, RESP_SLVERR});
    // First match is at FFh, later ones at the new period 3
    wr(OFS_COUNT_HIGH, 8'h03);
    wr(OFS_CONTROL_B, 8'h40);
    wr(OFS_COUNT_LOW, 8'h00);
    wr(OFS_CONTROL_A, 8'h80);
    repeat (300) @(posedge aclk);
    span(9, 11);
    wr(OFS_CONTROL_A, 8'h81);
    span(4, 6);
    wr(OFS_CONTROL_A, 8'h00);
    repeat (20) @(posedge aclk);
    rd(OFS_IRQ_FLAG); chk(rdv, 8'h01);
    rd(OFS_CONTROL_A); chk({7'h00, rdv[5]}, {7'h00, n_rise[0]});
    chk({7'h00, tmr_out.timer_out}, {7'h00, n_rise[0]});
    wr(OFS_IRQ_FLAG, 8'h00);
    rd(OFS_IRQ_FLAG); chk(rdv, 8'h00);
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_CONTROL_A, 8'h80);
    wr(OFS_COUNT_LOW, 8'h00);
    edges(8'h02);
    rd(OFS_COUNT_LOW); chk(rdv, 8'h02);
    wr(OFS_CONTROL_B, 8'h02);
    wr(OFS_COUNT_LOW, 8'h00);
    edges(8'h08);
    rd(OFS_COUNT_LOW); chk(rdv, 8'h02);
    wr(OFS_CONTROL_B, 8'h00);
    wr(OFS_COUNT_LOW, 8'h00);
    @(posedge aclk);
    sleep_in <= 1'b1;
    edges(8'h03);
    rd(OFS_COUNT_LOW); chk(rdv, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_CONTROL_B, 8'h10);
    wr(OFS_COUNT_LOW, 8'h00);
    edges(8'h02);
    rd(OFS_COUNT_LOW); chk(rdv, 8'h02);
    edges(8'h02);
    chk({7'h00, tmr_out.wake}, 8'h01);
    chk({7'h00, tmr_out.irq}, 8'h01);
    @(posedge aclk);
    sleep_in <= 1'b0;
    wr(OFS_IRQ_FLAG, 8'h00);
    @(negedge aclk);
    chk({7'h00, tmr_out.irq}, 8'h00);
    wr(OFS_CONTROL_A, 8'h10);
    wr(OFS_COUNT_HIGH, 8'h12);
    wr(OFS_COUNT_LOW, 8'h34);
    rd(OFS_COUNT_LOW); chk(rdv, 8'h34);
    rd(OFS_COUNT_HIGH); chk(rdv, 8'h12);
    wr(OFS_COUNT_HIGH, 8'hFF);
    wr(OFS_COUNT_LOW, 8'hFC);
    wr(OFS_CONTROL_B, 8'h40);
    wr(OFS_CONTROL_A, 8'h90);
    repeat (4) @(posedge aclk);
    rd(OFS_IRQ_FLAG); chk(rdv, 8'h01);
    chk({7'h00, tmr_out.irq}, 8'h01);
    chk({7'h00, tmr_out.wake}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
